// ===== rtl/sdcj_job_engine.sv
// Job decoder and executor for the diagnostic command group
// Operation
// - A job 33h with second byte 00h returns the echo values of slaves 1 to 29 and 1B to 31B.
// - Each echo value is what that slave returned to its latest parameter call.
// - Echoes pack two nibbles a byte, slave 1 low in byte 1, 1B low in byte 16.
// - The job is at most 223 bytes and the send count comes from byte 2.
// - The string bytes are forwarded to the addressed slave.
// - The reply holds the response length in byte 0 and its bytes after it.
// - String contents start at string byte 1 and are passed on uninterpreted.
// - Cyclic exchange with the addressed slave is held off during a transfer.
// - A job 14h reports the firmware version identification.
// - The version reply is a 32 byte string with name and version number.
// - A job 17h reads the slave ID code into the low nibble of reply byte 0.
// - A job 37h reads the extended ID1 code into the low nibble of byte 0.
`timescale 1ns/10ps
module sdcj_job_engine
  import sdcj_pkg::*;
#(
  // Arbitrary neutral identification text
  parameter logic [255:0] VERSION_STR = "DIAG JOB MASTER FW 0.1.0        "
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic jobValid,
  input wire logic [7:0] jobByte,
  input wire logic jobLast,
  output logic jobReady,
  output logic replyValid,
  output logic [7:0] replyByte,
  output logic replyLast,
  output logic jobDone,
  output logic jobError,
  input wire logic echoWrValid,
  input wire logic [5:0] echoWrSlave,
  input wire logic [3:0] echoWrValue,
  output logic idReqValid,
  output logic idReqExt,
  output logic [7:0] idReqAddr,
  input wire logic idRspValid,
  input wire logic idRspErr,
  input wire logic [3:0] idRspCode,
  output logic strTxValid,
  output logic [7:0] strTxByte,
  output logic strTxLast,
  input wire logic strTxReady,
  input wire logic strRxValid,
  input wire logic [7:0] strRxByte,
  input wire logic strRxLast,
  input wire logic strRxErr,
  output logic cyclicHold,
  output logic [7:0] cyclicHoldAddr
);

  // ---------------------------------------------
  // Storage
  // ---------------------------------------------
  logic [3:0] echoMem [64];
  logic [7:0] strMem [STR_DEPTH];
  logic memWe;
  logic [7:0] memIdx;
  logic [7:0] memData;

  // Echo store, updated by the cyclic parameter traffic
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 64; i++) begin
        echoMem[i] <= ECHO_RESET;
      end
    end else if (echoWrValid) begin
      echoMem[echoWrSlave] <= echoWrValue;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (memWe) begin
      strMem[memIdx] <= memData;
    end
  end

  // ---------------------------------------------
  // Control state
  // ---------------------------------------------
  sdcj_state_t state_q, state_d;
  logic [7:0] jIdx_q, jIdx_d, cmd_q, cmd_d, addr_q, addr_d, len_q, len_d;
  logic [7:0] idx_q, idx_d, end_q, end_d;
  logic over_q, over_d;
  logic [1:0] kind_q, kind_d;
  logic [3:0] idCode_q, idCode_d;
  logic jobReady_q, jobReady_d, replyValid_q, replyValid_d;
  logic [7:0] replyByte_q, replyByte_d;
  logic replyLast_q, replyLast_d, jobDone_q, jobDone_d;
  logic jobError_q, jobError_d, idReqValid_q, idReqValid_d;
  logic idReqExt_q, idReqExt_d, strTxValid_q, strTxValid_d;
  logic [7:0] strTxByte_q, strTxByte_d;
  logic strTxLast_q, strTxLast_d, cyclicHold_q, cyclicHold_d;
  logic [7:0] curCmd, curAddr, curLen, nBytes, srcByte;
  logic [5:0] hiSel, loSel;

  // Reply byte for index idx_q
  always_comb begin
    hiSel = 6'h00;
    loSel = 6'h00;
    srcByte = 8'h00;
    case (kind_q)
      KIND_ECHO: begin
        if (idx_q < B_SLAVE_FIRST_BYTE) begin
          hiSel = {idx_q[4:0], 1'b0} - 6'd2;
          loSel = {idx_q[4:0], 1'b0} - 6'd1;
        end else begin
          hiSel = {1'b1, idx_q[3:0], 1'b0};
          loSel = {1'b1, idx_q[3:0], 1'b1};
        end
        if (idx_q != 8'h00) begin
          srcByte[3:0] = echoMem[loSel];
          if (idx_q != 8'h01 && idx_q != B_SLAVE_FIRST_BYTE) begin
            srcByte[7:4] = echoMem[hiSel];
          end
        end
      end
      KIND_VERSION: srcByte = VERSION_STR[8 * (31 - idx_q[4:0]) +: 8];
      KIND_ID: srcByte = {4'h0, idCode_q};
      KIND_STRING: begin
        if (idx_q == 8'h00) begin
          srcByte = len_q;
        end else begin
          srcByte = strMem[idx_q - 8'd1];
        end
      end
      default: srcByte = 8'h00;
    endcase
  end

  always_comb begin
    state_d = state_q;
    jIdx_d = jIdx_q;
    cmd_d = cmd_q;
    addr_d = addr_q;
    len_d = len_q;
    idx_d = idx_q;
    end_d = end_q;
    over_d = over_q;
    kind_d = kind_q;
    idCode_d = idCode_q;
    jobReady_d = jobReady_q;
    replyValid_d = 1'b0;
    replyByte_d = 8'h00;
    replyLast_d = 1'b0;
    jobDone_d = 1'b0;
    jobError_d = 1'b0;
    idReqValid_d = 1'b0;
    idReqExt_d = idReqExt_q;
    strTxValid_d = strTxValid_q;
    strTxByte_d = strTxByte_q;
    strTxLast_d = strTxLast_q;
    cyclicHold_d = cyclicHold_q;
    memWe = 1'b0;
    memIdx = 8'h00;
    memData = 8'h00;
    curCmd = (jIdx_q == 8'd0) ? jobByte : cmd_q;
    curAddr = (jIdx_q == 8'd1) ? jobByte : addr_q;
    curLen = (jIdx_q == 8'd2) ? jobByte : len_q;
    nBytes = jIdx_q + 8'd1;
    case (state_q)
      ST_COLLECT: begin
        if (jobValid && jobReady_q) begin
          if (jIdx_q == 8'd0) cmd_d = jobByte;
          if (jIdx_q == 8'd1) addr_d = jobByte;
          if (jIdx_q == 8'd2) len_d = jobByte;
          if (jIdx_q >= STR_HDR_BYTES &&
              jIdx_q - STR_HDR_BYTES < STR_MAX_BYTES) begin
            memWe = 1'b1;
            memIdx = jIdx_q - STR_HDR_BYTES;
            memData = jobByte;
          end
          if (jIdx_q == JOB_MAX_BYTES) begin
            over_d = 1'b1;
          end else begin
            jIdx_d = nBytes;
          end
          if (jobLast) begin
            jIdx_d = 8'd0;
            over_d = 1'b0;
            jobReady_d = 1'b0;
            idx_d = 8'd0;
            jobError_d = 1'b1;
            jobDone_d = 1'b1;
            if (!over_q && jIdx_q != JOB_MAX_BYTES) begin
              case (curCmd)
                CMD_ECHO_LIST: begin
                  if (nBytes >= 8'd2 && curAddr == CMD_ECHO_SUB) begin
                    kind_d = KIND_ECHO;
                    end_d = ECHO_LAST_IDX;
                    state_d = ST_REPLY;
                  end
                end
                CMD_VERSION: begin
                  kind_d = KIND_VERSION;
                  end_d = VERSION_LAST_IDX;
                  state_d = ST_REPLY;
                end
                CMD_SLAVE_ID, CMD_SLAVE_EXT_ID1: begin
                  if (nBytes >= 8'd2) begin
                    idReqValid_d = 1'b1;
                    idReqExt_d = (curCmd == CMD_SLAVE_EXT_ID1);
                    state_d = ST_ID_WAIT;
                  end
                end
                CMD_STRING_XCHG: begin
                  if (nBytes >= STR_HDR_BYTES && curLen <= STR_MAX_BYTES &&
                      nBytes - STR_HDR_BYTES >= curLen) begin
                    cyclicHold_d = 1'b1;
                    state_d = (curLen == 8'd0) ? ST_STR_RX : ST_STR_TX;
                  end
                end
                default: state_d = ST_COLLECT;
              endcase
            end
            if (state_d != ST_COLLECT) begin
              jobError_d = 1'b0;
              jobDone_d = 1'b0;
            end else begin
              jobReady_d = 1'b1;
            end
          end
        end
      end
      ST_ID_WAIT: begin
        if (idRspValid) begin
          idCode_d = idRspCode;
          kind_d = KIND_ID;
          end_d = 8'd0;
          state_d = ST_REPLY;
          if (idRspErr) begin
            jobDone_d = 1'b1;
            jobError_d = 1'b1;
            jobReady_d = 1'b1;
            state_d = ST_COLLECT;
          end
        end
      end
      ST_STR_TX: begin
        if (!strTxValid_q) begin
          strTxValid_d = 1'b1;
          strTxByte_d = strMem[idx_q];
          strTxLast_d = (idx_q == len_q - 8'd1);
        end else if (strTxReady) begin
          strTxValid_d = 1'b0;
          strTxLast_d = 1'b0;
          idx_d = idx_q + 8'd1;
          if (strTxLast_q) begin
            idx_d = 8'd0;
            state_d = ST_STR_RX;
          end
        end
      end
      ST_STR_RX: begin
        if (strRxErr || (strRxValid && idx_q == STR_MAX_BYTES)) begin
          cyclicHold_d = 1'b0;
          jobDone_d = 1'b1;
          jobError_d = 1'b1;
          jobReady_d = 1'b1;
          state_d = ST_COLLECT;
        end else if (strRxValid) begin
          memWe = 1'b1;
          memIdx = idx_q;
          memData = strRxByte;
          idx_d = idx_q + 8'd1;
          if (strRxLast) begin
            cyclicHold_d = 1'b0;
            len_d = idx_q + 8'd1;
            end_d = idx_q + 8'd1;
            idx_d = 8'd0;
            kind_d = KIND_STRING;
            state_d = ST_REPLY;
          end
        end
      end
      ST_REPLY: begin
        replyValid_d = 1'b1;
        replyByte_d = srcByte;
        replyLast_d = (idx_q == end_q);
        idx_d = idx_q + 8'd1;
        if (idx_q == end_q) begin
          idx_d = 8'd0;
          jobDone_d = 1'b1;
          jobReady_d = 1'b1;
          state_d = ST_COLLECT;
        end
      end
      default: begin
        state_d = ST_COLLECT;
        jobReady_d = 1'b1;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_COLLECT;
      jIdx_q <= 8'h00;
      cmd_q <= 8'h00;
      addr_q <= 8'h00;
      len_q <= 8'h00;
      idx_q <= 8'h00;
      end_q <= 8'h00;
      over_q <= 1'b0;
      kind_q <= KIND_ECHO;
      idCode_q <= 4'h0;
      jobReady_q <= 1'b1;
      replyValid_q <= 1'b0;
      replyByte_q <= 8'h00;
      replyLast_q <= 1'b0;
      jobDone_q <= 1'b0;
      jobError_q <= 1'b0;
      idReqValid_q <= 1'b0;
      idReqExt_q <= 1'b0;
      strTxValid_q <= 1'b0;
      strTxByte_q <= 8'h00;
      strTxLast_q <= 1'b0;
      cyclicHold_q <= 1'b0;
    end else begin
      state_q <= state_d;
      jIdx_q <= jIdx_d;
      cmd_q <= cmd_d;
      addr_q <= addr_d;
      len_q <= len_d;
      idx_q <= idx_d;
      end_q <= end_d;
      over_q <= over_d;
      kind_q <= kind_d;
      idCode_q <= idCode_d;
      jobReady_q <= jobReady_d;
      replyValid_q <= replyValid_d;
      replyByte_q <= replyByte_d;
      replyLast_q <= replyLast_d;
      jobDone_q <= jobDone_d;
      jobError_q <= jobError_d;
      idReqValid_q <= idReqValid_d;
      idReqExt_q <= idReqExt_d;
      strTxValid_q <= strTxValid_d;
      strTxByte_q <= strTxByte_d;
      strTxLast_q <= strTxLast_d;
      cyclicHold_q <= cyclicHold_d;
    end
  end

  assign jobReady = jobReady_q;
  assign replyValid = replyValid_q;
  assign replyByte = replyByte_q;
  assign replyLast = replyLast_q;
  assign jobDone = jobDone_q;
  assign jobError = jobError_q;
  assign idReqValid = idReqValid_q;
  assign idReqExt = idReqExt_q;
  assign idReqAddr = addr_q;
  assign strTxValid = strTxValid_q;
  assign strTxByte = strTxByte_q;
  assign strTxLast = strTxLast_q;
  assign cyclicHold = cyclicHold_q;
  assign cyclicHoldAddr = addr_q;

endmodule

// ===== rtl/sdcj_pkg.sv
// Constants for the slave diagnostic command job engine
package sdcj_pkg;
  localparam logic [7:0] CMD_ECHO_LIST = 8'h33;
  localparam logic [7:0] CMD_ECHO_SUB = 8'h00;
  localparam logic [7:0] CMD_STRING_XCHG = 8'h44;
  localparam logic [7:0] CMD_VERSION = 8'h14;
  localparam logic [7:0] CMD_SLAVE_ID = 8'h17;
  localparam logic [7:0] CMD_SLAVE_EXT_ID1 = 8'h37;
  localparam logic [7:0] JOB_MAX_BYTES = 8'd223;
  localparam logic [7:0] STR_HDR_BYTES = 8'd3;
  localparam logic [7:0] STR_MAX_BYTES = 8'd220;
  localparam int STR_DEPTH = 220;
  localparam logic [7:0] ECHO_LAST_IDX = 8'd31;
  localparam logic [7:0] VERSION_LAST_IDX = 8'd31;
  localparam logic [7:0] B_SLAVE_FIRST_BYTE = 8'd16;
  localparam logic [3:0] ECHO_RESET = 4'h0;
  localparam logic [1:0] KIND_ECHO = 2'h0;
  localparam logic [1:0] KIND_VERSION = 2'h1;
  localparam logic [1:0] KIND_ID = 2'h2;
  localparam logic [1:0] KIND_STRING = 2'h3;
  typedef enum logic [4:0] {
    ST_COLLECT = 5'h01,
    ST_ID_WAIT = 5'h02,
    ST_STR_TX = 5'h04,
    ST_STR_RX = 5'h08,
    ST_REPLY = 5'h10
  } sdcj_state_t;
endpackage

// ===== verification/sdcj_cable_model.sv
// Cable side model: answers ID reads and string transfers
`timescale 1ns/10ps
module sdcj_cable_model (
  input wire logic sys_clk,
  input wire logic slow,
  input wire logic [3:0] idCode,
  input wire logic idFail,
  input wire logic idReqValid,
  input wire logic strTxValid,
  input wire logic [7:0] strTxByte,
  input wire logic strTxLast,
  output logic idRspValid,
  output logic idRspErr,
  output logic [3:0] idRspCode,
  output logic strTxReady,
  output logic strRxValid,
  output logic [7:0] strRxByte,
  output logic strRxLast,
  output logic strRxErr
);
  logic [7:0] rsp[$];
  initial begin
    idRspValid = 1'b0;
    idRspErr = 1'b0;
    idRspCode = 4'h0;
    strTxReady = 1'b0;
    strRxValid = 1'b0;
    strRxByte = 8'h00;
    strRxLast = 1'b0;
  end
  assign strRxErr = 1'b0;
  // Released code lines show the inverse value
  always begin
    @(posedge sys_clk);
    if (idReqValid) begin
      repeat (slow ? 5 : 1) @(posedge sys_clk);
      idRspValid <= 1'b1;
      idRspErr <= idFail;
      idRspCode <= idCode;
      @(posedge sys_clk);
      idRspValid <= 1'b0;
      idRspErr <= 1'b0;
      idRspCode <= ~idCode;
    end
  end
  always @(posedge sys_clk) strTxReady <= slow ? ~strTxReady : 1'b1;
  // Slave answers each byte with its value plus one
  always begin
    @(posedge sys_clk);
    if (strTxValid && strTxReady) begin
      rsp.push_back(strTxByte + 8'h01);
      if (strTxLast) begin
        repeat (slow ? 9 : 2) @(posedge sys_clk);
        foreach (rsp[i]) begin
          strRxValid <= 1'b1;
          strRxByte <= rsp[i];
          strRxLast <= (i == rsp.size() - 1);
          @(posedge sys_clk);
        end
        strRxValid <= 1'b0;
        strRxLast <= 1'b0;
        strRxByte <= ~strRxByte;
        rsp.delete();
      end
    end
  end
endmodule

// ===== verification/sdcj_job_engine_sva.sv
// Port checker for the job engine
`timescale 1ns/10ps
module sdcj_job_engine_sva
  import sdcj_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic jobValid,
  input wire logic [7:0] jobByte,
  input wire logic jobLast,
  input wire logic jobReady,
  input wire logic replyValid,
  input wire logic [7:0] replyByte,
  input wire logic replyLast,
  input wire logic jobDone,
  input wire logic jobError,
  input wire logic idReqValid,
  input wire logic [7:0] idReqAddr,
  input wire logic idRspValid,
  input wire logic idRspErr,
  input wire logic [3:0] idRspCode,
  input wire logic strTxValid,
  input wire logic [7:0] strTxByte,
  input wire logic strTxReady,
  input wire logic strRxValid,
  input wire logic strRxLast,
  input wire logic cyclicHold,
  input wire logic [7:0] cyclicHoldAddr
);
  logic firstByte_q;
  logic secondByte_q;
  logic [7:0] jobAddr_q;
  logic idWait_q;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      firstByte_q <= 1'b1;
      secondByte_q <= 1'b0;
      jobAddr_q <= 8'h00;
      idWait_q <= 1'b0;
    end else begin
      if (jobValid && jobReady) begin
        firstByte_q <= jobLast;
        secondByte_q <= firstByte_q && !jobLast;
        if (secondByte_q) jobAddr_q <= jobByte;
      end
      if (idReqValid) idWait_q <= 1'b1;
      else if (jobDone) idWait_q <= 1'b0;
    end
  end
  property p_err_quiet; jobError |-> jobDone && !replyValid; endproperty
  a_err_quiet: assert property (p_err_quiet)
    else $error("error pulse with reply data");
  property p_version;
    firstByte_q && jobValid && jobReady && jobLast && jobByte == CMD_VERSION
    |-> ##2 replyValid ##31 replyLast && jobDone;
  endproperty
  a_version: assert property (p_version)
    else $error("version reply not 32 bytes");
  property p_id_reply;
    idWait_q && idRspValid && !idRspErr |-> ##2 replyValid && replyLast
    && jobDone && replyByte == {4'h0, $past(idRspCode, 2)};
  endproperty
  a_id_reply: assert property (p_id_reply)
    else $error("ID reply wrong");
  property p_id_err; idWait_q && idRspValid && idRspErr |=> jobError; endproperty
  a_id_err: assert property (p_id_err)
    else $error("failed ID read not flagged");
  property p_tx_hold;
    strTxValid |-> cyclicHold && cyclicHoldAddr == jobAddr_q && !jobReady;
  endproperty
  a_tx_hold: assert property (p_tx_hold)
    else $error("cyclic exchange not held");
  property p_id_addr; idReqValid |-> idReqAddr == jobAddr_q; endproperty
  a_id_addr: assert property (p_id_addr)
    else $error("ID read sent to wrong slave");
  property p_busy;
    jobValid && jobReady && jobLast |=> !jobReady || jobDone;
  endproperty
  a_busy: assert property (p_busy)
    else $error("job input not closed while busy");
  property p_ready_done; jobDone |-> jobReady; endproperty
  a_ready_done: assert property (p_ready_done)
    else $error("job input not reopened at done");
  property p_tx_stable;
    strTxValid && !strTxReady |=> strTxValid && $stable(strTxByte);
  endproperty
  a_tx_stable: assert property (p_tx_stable)
    else $error("string byte dropped");
  property p_burst; replyValid && !replyLast |=> replyValid; endproperty
  a_burst: assert property (p_burst)
    else $error("reply gap");
  property p_last_done; replyLast |-> replyValid && jobDone; endproperty
  a_last_done: assert property (p_last_done)
    else $error("last byte without done");
  property p_rx_release;
    cyclicHold && strRxValid && strRxLast |=> !cyclicHold ##1 replyValid;
  endproperty
  a_rx_release: assert property (p_rx_release)
    else $error("hold not released");
  c_reply: cover property (replyLast);
  c_error: cover property (jobError);
  c_stall: cover property (strTxValid && !strTxReady);
endmodule

bind sdcj_job_engine sdcj_job_engine_sva u_sva (
  .sys_clk, .rst, .jobValid, .jobByte, .jobLast, .jobReady, .replyValid,
  .replyByte, .replyLast, .jobDone, .jobError, .idReqValid, .idReqAddr,
  .idRspValid, .idRspErr, .idRspCode, .strTxValid, .strTxByte,
  .strTxReady, .strRxValid, .strRxLast, .cyclicHold, .cyclicHoldAddr
);

// ===== verification/sdcj_job_engine_tb.sv
// Testbench for the diagnostic command job engine
`timescale 1ns/10ps
module sdcj_job_engine_tb
  import sdcj_pkg::*;
;
  // Arbitrary version text
  localparam logic [255:0] VSTR = "TB VERSION STRING 0123456789ABCD";
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic jobValid = 1'b0;
  logic [7:0] jobByte = 8'h00;
  logic jobLast = 1'b0;
  logic echoWrValid = 1'b0;
  logic [5:0] echoWrSlave = 6'h00;
  logic [3:0] echoWrValue = 4'h0;
  logic slow = 1'b0;
  logic [3:0] idCode = 4'h0;
  logic idFail = 1'b0;
  logic jobReady, replyValid, replyLast, jobDone, jobError, idReqValid;
  logic idReqExt, strTxValid, strTxLast, strTxReady, strRxValid, strRxLast;
  logic strRxErr, idRspValid, idRspErr, cyclicHold, gotErr;
  logic [7:0] replyByte, idReqAddr, strTxByte, strRxByte, cyclicHoldAddr;
  logic [7:0] holdAddr;
  logic [3:0] idRspCode;
  logic [7:0] rq[$];
  int errors = 0;
  int n_compared = 0;
  always #20 sys_clk = ~sys_clk;
  sdcj_job_engine #(.VERSION_STR(VSTR)) dut (
    .sys_clk, .rst, .jobValid, .jobByte, .jobLast, .jobReady, .replyValid,
    .replyByte, .replyLast, .jobDone, .jobError, .echoWrValid, .echoWrSlave,
    .echoWrValue, .idReqValid, .idReqExt, .idReqAddr, .idRspValid,
    .idRspErr, .idRspCode, .strTxValid, .strTxByte, .strTxLast, .strTxReady,
    .strRxValid, .strRxByte, .strRxLast, .strRxErr, .cyclicHold,
    .cyclicHoldAddr
  );
  sdcj_cable_model cable (
    .sys_clk, .slow, .idCode, .idFail, .idReqValid, .strTxValid, .strTxByte,
    .strTxLast, .idRspValid, .idRspErr, .idRspCode, .strTxReady,
    .strRxValid, .strRxByte, .strRxLast, .strRxErr
  );
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task end_sim;
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Send one job, then gather the reply until done
  task run(input logic [7:0] q[$]);
    int n;
    foreach (q[i]) begin
      jobValid <= 1'b1;
      jobByte <= q[i];
      jobLast <= (i == q.size() - 1);
      @(posedge sys_clk);
    end
    jobValid <= 1'b0;
    jobLast <= 1'b0;
    rq.delete();
    holdAddr = 8'h00;
    n = 0;
    do begin
      @(negedge sys_clk);
      if (replyValid) rq.push_back(replyByte);
      if (cyclicHold) holdAddr = cyclicHoldAddr;
      n++;
    end while (jobDone !== 1'b1 && n < 4000);
    gotErr = jobError;
    if (jobDone !== 1'b1) begin
      errors++;
      $display("BAD %0t job hang", $time);
      end_sim();
    end else begin
      @(posedge sys_clk);
    end
  endtask
  function logic [3:0] ex(input bit b, input int s);
    if (s == 0) return 4'h0;
    if (!b && s == 1) return 4'hc;
    return 4'(s) ^ (b ? 4'ha : 4'h5);
  endfunction
  function logic [7:0] eb(input int k);
    int lo;
    bit b;
    b = k >= 16;
    lo = b ? 2 * k - 31 : 2 * k - 1;
    return (k == 0) ? 8'h00 : {ex(b, lo - 1), ex(b, lo)};
  endfunction
  task t_version;
    run({CMD_VERSION});
    chk(8'(rq.size()), 8'd32);
    foreach (rq[k]) chk(rq[k], VSTR[255 - 8 * k -: 8]);
  endtask
  task t_echo;
    for (int i = 0; i < 64; i++) begin
      echoWrValid <= 1'b1;
      echoWrSlave <= 6'(i);
      echoWrValue <= 4'(i) ^ (i[5] ? 4'ha : 4'h5);
      @(posedge sys_clk);
    end
    echoWrSlave <= 6'h01;
    echoWrValue <= 4'h9;
    @(posedge sys_clk);
    echoWrValue <= 4'hc;
    @(posedge sys_clk);
    echoWrValid <= 1'b0;
    run({CMD_ECHO_LIST, CMD_ECHO_SUB});
    chk(8'(rq.size()), 8'd32);
    foreach (rq[k]) chk(rq[k], eb(k));
  endtask
  task t_id(input bit ext, input bit sl);
    slow <= sl;
    idCode <= ext ? 4'h6 : 4'h9;
    run({ext ? CMD_SLAVE_EXT_ID1 : CMD_SLAVE_ID, 8'h1d});
    chk({7'h0, idReqExt}, {7'h0, ext});
    chk(idReqAddr, 8'h1d);
    chk(8'(rq.size()), 8'd1);
    chk(rq[0], ext ? 8'h06 : 8'h09);
  endtask
  task t_string(input bit sl);
    slow <= sl;
    run({CMD_STRING_XCHG, 8'h05, 8'h03, 8'ha0, 8'ha1, 8'ha2, 8'hee});
    chk({7'h0, gotErr}, 8'h00);
    chk(8'(rq.size()), 8'd4);
    chk(rq[0], 8'h03);
    for (int k = 1; k < 4; k++) chk(rq[k], 8'ha0 + 8'(k));
    chk(holdAddr, 8'h05);
    chk({7'h0, cyclicHold}, 8'h00);
  endtask
  // Longest legal string job, then one byte too many
  task t_long;
    logic [7:0] q[$];
    q = {CMD_STRING_XCHG, 8'h07, STR_MAX_BYTES};
    for (int k = 0; k < 220; k++) q.push_back(8'(k));
    run(q);
    chk({7'h0, gotErr}, 8'h00);
    chk(8'(rq.size()), 8'hdd);
    chk(rq[0], STR_MAX_BYTES);
    chk(rq[220], 8'hdc);
    q.push_back(8'h00);
    err_job(q);
  endtask
  task err_job(input logic [7:0] q[$]);
    run(q);
    chk({7'h0, gotErr}, 8'h01);
    chk(8'(rq.size()), 8'd0);
  endtask
  initial begin
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    t_version();
    t_echo();
    t_id(1'b0, 1'b0);
    t_id(1'b1, 1'b1);
    t_string(1'b0);
    t_string(1'b1);
    t_long();
    err_job({8'h99});
    err_job({CMD_ECHO_LIST, 8'h01});
    err_job({CMD_STRING_XCHG, 8'h05, 8'h03, 8'ha0});
    err_job({CMD_STRING_XCHG, 8'h05, 8'hdd, 8'h00});
    idFail <= 1'b1;
    err_job({CMD_SLAVE_ID, 8'h02});
    end_sim();
  end
endmodule
